// ==== verification/itc_pins_model.sv ====
// Field wiring model that drives each counter's clock and gate lines.
`timescale 1ns/1ps
module itc_pins_model (
    // Clock.
    input wire logic clk,
    // Counter pins.
    output itc_pkg::itc_pins_s [2:0] pins
);
    import itc_pkg::*;
    // Clocks idle low and gates idle high, so counting is enabled by default.
    initial begin
        pins = 6'h15;
    end
    // One positive count pulse, long enough to pass the input synchronisers.
    task automatic pulse(input int c);
        @(posedge clk);
        #2 pins[c].clk = 1'b1;
        repeat (4) @(posedge clk);
        #2 pins[c].clk = 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic gate(input int c, input logic v);
        @(posedge clk);
        #2 pins[c].gate = v;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ==== verification/itc_timer_props.sv ====
// Port-level checks for the three-counter timer.
`timescale 1ns/1ps
module itc_timer_props (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Host register port.
    input wire logic [2:0] addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    // Counter pins and options.
    input wire itc_pkg::itc_pins_s [2:0] pins,
    input wire logic [2:0] cnt_out,
    input wire logic oscillator_clock_option,
    input wire logic cascade_clock_option,
    input wire logic chained_gate_option
);
    import itc_pkg::*;
    logic m0, next_m0, pclk, next_pclk, ctrl0, w0;
    logic [3:0] since0, next_since0, quiet0, next_quiet0;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    assign ctrl0 = wr_stb && addr == ITC_OFS_CTRL && wr_data[7:6] == 2'h0
        && wr_data[5:4] != ITC_ACC_LATCH;
    assign w0 = wr_stb && (addr == ITC_OFS_CNT0 || addr == ITC_OFS_CTRL);
    // Tracks counter 0 mode, time since its last cause of change, and time since a write.
    always_comb begin
        next_m0 = ctrl0 ? (wr_data[3:1] == 3'h0) : m0;
        next_pclk = pins[0].clk;
        next_since0 = (w0 || (pins[0].clk && !pclk)) ? 4'h0 : since0 + 4'(since0 != 4'hf);
        next_quiet0 = w0 ? 4'h0 : quiet0 + 4'(quiet0 != 4'hf);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {m0, pclk, since0, quiet0} <= {2'h0, 4'hf, 4'h0};
        end else begin
            {m0, pclk, since0, quiet0} <= {next_m0, next_pclk, next_since0, next_quiet0};
        end
    end
    sequence ctrl_m0_s;
        ctrl0 && wr_data[3:1] == 3'h0;
    endsequence
    sequence ctrl_other_s;
        ctrl0 && wr_data[3:1] != 3'h0;
    endsequence
    reset_values_a: assert property ($fell(rst) |-> rd_data == 8'h00 && cnt_out == 3'h0)
        else $error("outputs not at reset values after reset");
    read_hold_a: assert property (!rd_stb |=> $stable(rd_data))
        else $error("read data changed without a read");
    unmapped_read_a: assert property (rd_stb && addr < ITC_OFS_CNT0 |=> $stable(rd_data))
        else $error("unmapped read changed read data");
    mode0_load_a: assert property (ctrl_m0_s |-> ##[1:3] !cnt_out[0])
        else $error("mode 0 control word left counter 0 output high");
    mode_other_a: assert property (ctrl_other_s |-> ##[1:3] cnt_out[0])
        else $error("control word for another mode left counter 0 output low");
    mode0_stays_a: assert property (m0 && quiet0 > 4'h4 && cnt_out[0] |=> cnt_out[0])
        else $error("mode 0 output fell without a reload");
    pulse_cause_a: assert property ($fell(cnt_out[0]) |-> since0 < 4'ha)
        else $error("counter 0 output fell without a count pulse or write");
    mode4_idle_a: assert property (wr_stb && addr == ITC_OFS_CTRL && wr_data[7:6] == 2'h2
        && wr_data[5:4] != 2'h0 && wr_data[3:1] == 3'h4 |-> ##[1:3] cnt_out[2])
        else $error("mode 4 control word left counter 2 output low");
endmodule

bind itc_timer itc_timer_props props_u (.clk(clk), .rst(rst), .addr(addr), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data), .pins(pins), .cnt_out(cnt_out),
    .oscillator_clock_option(oscillator_clock_option),
    .cascade_clock_option(cascade_clock_option), .chained_gate_option(chained_gate_option));

// ==== verification/itc_timer_test.sv ====
// Self-checking bench for the three-counter timer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module itc_timer_test;
    import itc_pkg::*;
    logic clk, rst, wr_stb, rd_stb, osc, casc, chain, prv;
    logic [2:0] addr, cnt_out;
    logic [7:0] wr_data, rd_data, d;
    itc_pins_s [2:0] pins;
    int num_errors, n_checks, lows, c;
    logic [7:0] ctl_t [8] = '{8'h72, 8'h34, 8'hbc, 8'h36, 8'h7e, 8'hb8, 8'h3a, 8'hb8};
    int n_t [8] = '{3, 3, 3, 5, 4, 3, 3, 3};
    int tr_t [8] = '{1, 0, 0, 0, 0, 0, 1, 2};
    int np_t [8] = '{8, 9, 9, 20, 16, 8, 8, 8};
    int ex_t [8] = '{3, 3, 3, 8, 8, 1, 1, 0};
    itc_timer dut_u (.clk(clk), .rst(rst), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .wr_data(wr_data), .rd_data(rd_data), .pins(pins), .cnt_out(cnt_out),
        .oscillator_clock_option(osc), .cascade_clock_option(casc),
        .chained_gate_option(chain));
    itc_pins_model pm (.clk(clk), .pins(pins));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        #2 {addr, wr_data, wr_stb} = {a, v, 1'b1};
        @(posedge clk);
        #2 wr_stb = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        #2 {addr, rd_stb} = {a, 1'b1};
        @(posedge clk);
        #2 rd_stb = 1'b0;
        d = rd_data;
    endtask
    task automatic load(input int k, input logic [7:0] ctl, input logic [15:0] n);
        wr(ITC_OFS_CTRL, ctl);
        wr(3'(ITC_OFS_CNT0 + k), n[7:0]);
        wr(3'(ITC_OFS_CNT0 + k), n[15:8]);
    endtask
    // Counts low output samples taken just before each pulse, after warm-up pulses.
    task automatic run(input int pc, input int oc, input int warm, input int n);
        repeat (warm) pm.pulse(pc);
        lows = 0;
        repeat (n) begin
            #1 if (cnt_out[oc] === 1'b0) lows++;
            pm.pulse(pc);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {rst, wr_stb, rd_stb, osc, casc, chain, addr, wr_data} = {1'b1, 16'h0000};
        {num_errors, n_checks} = {32'd0, 32'd0};
        repeat (16) @(posedge clk);
        `CHK("reset out", 3'h0, cnt_out)
        #2 rst = 1'b0;
        load(0, 8'h30, 16'h0003);
        repeat (3) @(posedge clk);
        `CHK("load low", 1'b0, cnt_out[0])
        run(0, 0, 1, 8);
        `CHK("m0 lows", 3, lows)
        run(0, 0, 0, 8);
        `CHK("m0 hold", 0, lows)
        for (int i = 0; i < 8; i++) begin
            c = int'(ctl_t[i][7:6]);
            if (tr_t[i] != 0) pm.gate(c, 1'b0);
            load(c, ctl_t[i], 16'(n_t[i]));
            if (tr_t[i] == 1) pm.gate(c, 1'b1);
            run(c, c, 1, np_t[i]);
            `CHK("mode lows", ex_t[i], lows)
            pm.gate(c, 1'b1);
        end
        load(1, 8'h70, 16'h1234);
        pm.pulse(1);
        wr(ITC_OFS_CTRL, 8'h40);
        repeat (2) pm.pulse(1);
        rd(ITC_OFS_CNT1);
        `CHK("latch lo", 8'h34, d)
        rd(ITC_OFS_CNT1);
        `CHK("latch hi", 8'h12, d)
        rd(ITC_OFS_CNT1);
        `CHK("live lo", 8'h32, d)
        rd(ITC_OFS_CNT1);
        `CHK("live hi", 8'h12, d)
        wr(ITC_OFS_CTRL, 8'h90);
        wr(ITC_OFS_CNT2, 8'h05);
        pm.pulse(2);
        rd(ITC_OFS_CNT2);
        `CHK("low only", 8'h05, d)
        wr(ITC_OFS_CTRL, 8'ha0);
        wr(ITC_OFS_CNT2, 8'h01);
        repeat (2) pm.pulse(2);
        wr(ITC_OFS_CTRL, 8'hc4);
        rd(ITC_OFS_CNT2);
        `CHK("high only", 8'h00, d)
        load(0, 8'h31, 16'h0010);
        repeat (2) pm.pulse(0);
        wr(ITC_OFS_CTRL, 8'h00);
        rd(ITC_OFS_CNT0);
        `CHK("bcd lo", 8'h09, d)
        rd(3'h2);
        `CHK("unmapped", 8'h09, d)
        rd(ITC_OFS_CNT0);
        `CHK("bcd hi", 8'h00, d)
        osc = 1'b1;
        load(1, 8'h74, 16'h0004);
        repeat (100) @(posedge clk);
        {lows, prv} = {32'd0, cnt_out[1]};
        repeat (800) begin
            @(posedge clk);
            #2 if (prv === 1'b1 && cnt_out[1] === 1'b0) lows++;
            prv = cnt_out[1];
        end
        `CHK("osc lows", 800 / (ITC_OSC_DIV * 4), lows)
        {osc, casc} = 2'b01;
        load(1, 8'h74, 16'h0002);
        load(2, 8'hb4, 16'h0002);
        run(1, 2, 4, 16);
        `CHK("cascade lows", 8, lows)
        {casc, chain} = 2'b01;
        wr(ITC_OFS_CTRL, 8'h78);
        pm.gate(0, 1'b0);
        load(0, 8'h30, 16'h0003);
        run(0, 0, 1, 8);
        `CHK("chained gate", 3, lows)
        chain = 1'b0;
        load(0, 8'h30, 16'h0003);
        run(0, 0, 1, 8);
        `CHK("gate low", 8, lows)
        tally_and_finish();
    end
endmodule

// ==== verilog/itc_pkg.sv ====
// Package of constants and types for the three-counter interval timer.
package itc_pkg;
    localparam logic [2:0] ITC_OFS_CNT0 = 3'h4;
    localparam logic [2:0] ITC_OFS_CNT1 = 3'h5;
    localparam logic [2:0] ITC_OFS_CNT2 = 3'h6;
    localparam logic [2:0] ITC_OFS_CTRL = 3'h7;
    localparam int ITC_SEL_POS = 6;
    localparam int ITC_ACC_POS = 4;
    localparam int ITC_MODE_POS = 1;
    localparam int ITC_FMT_POS = 0;
    localparam logic [1:0] ITC_SEL_READBACK = 2'h3;
    localparam logic [1:0] ITC_ACC_LATCH = 2'h0;
    localparam logic [1:0] ITC_ACC_LOW = 2'h1;
    localparam logic [1:0] ITC_ACC_HIGH = 2'h2;
    localparam logic [1:0] ITC_ACC_BOTH = 2'h3;
    localparam logic [15:0] ITC_COUNT_RESET = 16'h0000;
    localparam logic [2:0] ITC_MODE_RESET = 3'h0;
    localparam logic [1:0] ITC_ACC_RESET = 2'h3;
    localparam logic [5:0] ITC_PINS_IDLE = 6'h15;
    localparam logic [2:0] ITC_GATE_IDLE = 3'h7;
    localparam int ITC_CLK_HZ = 20000000;
    localparam int ITC_OSC_HZ = 1000000;
    localparam int ITC_OSC_DIV = ITC_CLK_HZ / ITC_OSC_HZ;
    localparam logic [4:0] ITC_OSC_LAST = 5'(ITC_OSC_DIV - 1);

    typedef struct packed {
        logic [1:0] access;
        logic [2:0] mode;
        logic bcd;
    } itc_cfg_s;

    typedef struct packed {
        logic clk;
        logic gate;
    } itc_pins_s;
endpackage

// ==== verilog/itc_timer.sv ====
// Three 16-bit down counters with control word, latch and jumper options.
`timescale 1ns/1ps

module itc_timer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Host register port.
    input wire logic [2:0] addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    // Counter pins.
    input wire itc_pkg::itc_pins_s [2:0] pins,
    output logic [2:0] cnt_out,
    // Jumper options.
    input wire logic oscillator_clock_option,
    input wire logic cascade_clock_option,
    input wire logic chained_gate_option
);
    import itc_pkg::*;

    // Pin synchronisers: first stage read only by the second.
    logic [5:0] sync1, sync2, sync_prev;
    logic [4:0] osc_cnt;
    logic osc_tick;
    logic [4:0] next_osc_cnt;
    logic next_osc_tick;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Synchronisers start at the pins' idle levels so no false edge follows reset.
            sync1 <= ITC_PINS_IDLE;
            sync2 <= ITC_PINS_IDLE;
            sync_prev <= ITC_PINS_IDLE;
            osc_cnt <= 5'h00;
            osc_tick <= 1'b0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync_prev <= sync2;
            osc_cnt <= next_osc_cnt;
            osc_tick <= next_osc_tick;
        end
    end

    always_comb begin
        next_osc_cnt = (osc_cnt == ITC_OSC_LAST) ? 5'h00 : osc_cnt + 5'h01;
        next_osc_tick = (osc_cnt == ITC_OSC_LAST);
    end

    // Per-counter state.
    itc_cfg_s cfg [3];
    logic [15:0] count [3];
    logic [15:0] preset [3];
    logic [15:0] hold [3];
    logic [2:0] held;
    logic [2:0] wr_hi;
    logic [2:0] rd_hi;
    logic [7:0] lo_buf [3];
    logic [2:0] armed;
    logic [2:0] load_pend;
    logic [2:0] trig_pend;
    logic [2:0] outq;
    logic [2:0] phase;

    itc_cfg_s next_cfg [3];
    logic [15:0] next_count [3];
    logic [15:0] next_preset [3];
    logic [15:0] next_hold [3];
    logic [2:0] next_held;
    logic [2:0] next_wr_hi;
    logic [2:0] next_rd_hi;
    logic [7:0] next_lo_buf [3];
    logic [2:0] next_armed;
    logic [2:0] next_load_pend;
    logic [2:0] next_trig_pend;
    logic [2:0] next_outq;
    logic [2:0] next_phase;
    logic [7:0] next_rd_data;

    // One decrement in binary or BCD, by one, two or three.
    function automatic logic [15:0] dec(input logic [15:0] v, input logic bcd,
                                        input logic [1:0] step);
        logic [15:0] r;
        logic [3:0] d;
        logic [1:0] b;
        r = v;
        b = step;
        if (!bcd) begin
            r = v - {14'h0000, step};
        end else begin
            for (int i = 0; i < 4; i++) begin
                d = r[4*i +: 4];
                if ({2'b00, d} >= {2'b00, b}) begin
                    r[4*i +: 4] = d - {2'b00, b};
                    b = 2'h0;
                end else begin
                    r[4*i +: 4] = d + 4'ha - {2'b00, b};
                    b = 2'h1;
                end
            end
        end
        return r;
    endfunction

    logic [2:0] tick, gate, gate_rise, gate_prev;

    always_comb begin
        gate[0] = chained_gate_option ? outq[1] : sync2[0];
        gate[1] = sync2[2];
        gate[2] = sync2[4];
        gate_rise = gate & ~gate_prev;
        tick[0] = sync2[1] & ~sync_prev[1];
        tick[1] = oscillator_clock_option ? osc_tick : (sync2[3] & ~sync_prev[3]);
        tick[2] = cascade_clock_option ? (outq[1] & ~cnt_out[1]) :
                  (sync2[5] & ~sync_prev[5]);
    end

    always_comb begin
        logic [1:0] sel;
        logic [1:0] idx;
        logic [15:0] nv;
        logic [2:0] m;
        sel = wr_data[ITC_SEL_POS +: 2];
        idx = 2'h0;
        nv = 16'h0000;
        m = 3'h0;
        next_rd_data = rd_data;
        for (int c = 0; c < 3; c++) begin
            next_cfg[c] = cfg[c];
            next_count[c] = count[c];
            next_preset[c] = preset[c];
            next_hold[c] = hold[c];
            next_held[c] = held[c];
            next_wr_hi[c] = wr_hi[c];
            next_rd_hi[c] = rd_hi[c];
            next_lo_buf[c] = lo_buf[c];
            next_armed[c] = armed[c];
            next_load_pend[c] = load_pend[c];
            next_trig_pend[c] = trig_pend[c] | gate_rise[c];
            next_outq[c] = outq[c];
            next_phase[c] = phase[c];
            m = cfg[c].mode;
            m[2] = m[2] & ~m[1];
            // Counting on each count pulse.
            if (tick[c]) begin
                if (load_pend[c]) begin
                    next_count[c] = preset[c];
                    next_load_pend[c] = 1'b0;
                    next_phase[c] = 1'b0;
                end else if (trig_pend[c] && (m == 3'h1 || m == 3'h5)) begin
                    next_count[c] = preset[c];
                    next_trig_pend[c] = gate_rise[c];
                    next_armed[c] = 1'b1;
                    if (m == 3'h1) begin
                        next_outq[c] = 1'b0;
                    end
                end else begin
                    unique case (m)
                        3'h0, 3'h4: begin
                            if (gate[c] && armed[c]) begin
                                nv = dec(count[c], cfg[c].bcd, 2'h1);
                                next_count[c] = nv;
                                if (nv == 16'h0000) begin
                                    next_armed[c] = 1'b0;
                                    next_outq[c] = (m == 3'h0);
                                end
                            end else if (m == 3'h4) begin
                                next_outq[c] = 1'b1;
                            end
                        end
                        3'h1, 3'h5: begin
                            next_outq[c] = (m == 3'h1) ? outq[c] : 1'b1;
                            if (armed[c]) begin
                                nv = dec(count[c], cfg[c].bcd, 2'h1);
                                next_count[c] = nv;
                                if (nv == 16'h0000) begin
                                    next_armed[c] = 1'b0;
                                    next_outq[c] = (m == 3'h1);
                                end
                            end
                        end
                        3'h2: begin
                            next_outq[c] = 1'b1;
                            if (gate[c]) begin
                                nv = dec(count[c], cfg[c].bcd, 2'h1);
                                next_count[c] = (count[c] == 16'h0001) ? preset[c] : nv;
                                next_outq[c] = !(nv == 16'h0001);
                            end
                        end
                        3'h3: begin
                            if (gate[c]) begin
                                // Odd presets step 1 first when high and 3 first when low.
                                if (preset[c][0] && count[c] == preset[c]) begin
                                    nv = dec(count[c], cfg[c].bcd, phase[c] ? 2'h3 : 2'h1);
                                end else begin
                                    nv = dec(count[c], cfg[c].bcd, 2'h2);
                                end
                                if (nv == 16'h0000 || count[c] <= 16'h0002) begin
                                    next_count[c] = preset[c];
                                    next_phase[c] = ~phase[c];
                                    next_outq[c] = phase[c];
                                end else begin
                                    next_count[c] = nv;
                                end
                            end
                        end
                    endcase
                end
            end
        end
        // Host writes and reads.
        if (wr_stb && addr == ITC_OFS_CTRL) begin
            idx = sel;
            if (sel != ITC_SEL_READBACK) begin
                if (wr_data[ITC_ACC_POS +: 2] == ITC_ACC_LATCH) begin
                    if (!held[idx]) begin
                        next_hold[idx] = count[idx];
                        next_held[idx] = 1'b1;
                    end
                end else begin
                    next_cfg[idx] = wr_data[5:0];
                    next_wr_hi[idx] = 1'b0;
                    next_rd_hi[idx] = 1'b0;
                    next_armed[idx] = 1'b0;
                    next_outq[idx] = (wr_data[3:1] != 3'h0);
                end
            end
        end else if ((wr_stb || rd_stb) && addr >= ITC_OFS_CNT0 && addr != ITC_OFS_CTRL) begin
            idx = 2'(addr - ITC_OFS_CNT0);
            if (wr_stb) begin
                nv = preset[idx];
                unique case (cfg[idx].access)
                    ITC_ACC_LOW: nv = {8'h00, wr_data};
                    ITC_ACC_HIGH: nv = {wr_data, 8'h00};
                    default: begin
                        if (!wr_hi[idx]) begin
                            next_lo_buf[idx] = wr_data;
                        end
                        nv = {wr_data, lo_buf[idx]};
                    end
                endcase
                if (cfg[idx].access == ITC_ACC_BOTH && !wr_hi[idx]) begin
                    next_wr_hi[idx] = 1'b1;
                end else begin
                    next_wr_hi[idx] = 1'b0;
                    next_preset[idx] = nv;
                    next_load_pend[idx] = 1'b1;
                    next_armed[idx] = !(cfg[idx].mode == 3'h1 || cfg[idx].mode == 3'h5);
                    next_trig_pend[idx] = 1'b0;
                    if (cfg[idx].mode == 3'h0) begin
                        next_outq[idx] = 1'b0;
                    end
                end
            end else begin
                nv = held[idx] ? hold[idx] : count[idx];
                unique case (cfg[idx].access)
                    ITC_ACC_LOW: next_rd_data = nv[7:0];
                    ITC_ACC_HIGH: next_rd_data = nv[15:8];
                    default: next_rd_data = rd_hi[idx] ? nv[15:8] : nv[7:0];
                endcase
                if (cfg[idx].access == ITC_ACC_BOTH && !rd_hi[idx]) begin
                    next_rd_hi[idx] = 1'b1;
                end else begin
                    next_rd_hi[idx] = 1'b0;
                    next_held[idx] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < 3; c++) begin
                cfg[c] <= '{access: ITC_ACC_RESET, mode: ITC_MODE_RESET, bcd: 1'b0};
                count[c] <= ITC_COUNT_RESET;
                preset[c] <= ITC_COUNT_RESET;
                hold[c] <= ITC_COUNT_RESET;
                lo_buf[c] <= 8'h00;
            end
            held <= 3'h0;
            wr_hi <= 3'h0;
            rd_hi <= 3'h0;
            armed <= 3'h0;
            load_pend <= 3'h0;
            trig_pend <= 3'h0;
            outq <= 3'h0;
            phase <= 3'h0;
            gate_prev <= ITC_GATE_IDLE;
            cnt_out <= 3'h0;
            rd_data <= 8'h00;
        end else begin
            for (int c = 0; c < 3; c++) begin
                cfg[c] <= next_cfg[c];
                count[c] <= next_count[c];
                preset[c] <= next_preset[c];
                hold[c] <= next_hold[c];
                lo_buf[c] <= next_lo_buf[c];
            end
            held <= next_held;
            wr_hi <= next_wr_hi;
            rd_hi <= next_rd_hi;
            armed <= next_armed;
            load_pend <= next_load_pend;
            trig_pend <= next_trig_pend;
            outq <= next_outq;
            phase <= next_phase;
            gate_prev <= gate;
            cnt_out <= outq;
            rd_data <= next_rd_data;
        end
    end
endmodule
